// ### hdl/rtcarc_pkg.sv
package rtcarc_pkg;

   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned HALF_SEC_NS = 500000000;
   localparam int unsigned HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;
   localparam int unsigned BLK_RST_CYCLES = 4;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL1 = 8'h00;
   localparam logic [7:0] OFS_ALM_TIME = 8'h04;
   localparam logic [7:0] OFS_ALM_DATE = 8'h08;
   localparam logic [7:0] OFS_SET_TIME = 8'h0c;
   localparam logic [7:0] OFS_SET_DATE = 8'h10;
   localparam logic [7:0] OFS_CNT_TIME = 8'h14;
   localparam logic [7:0] OFS_CNT_DATE = 8'h18;
   localparam logic [7:0] OFS_IRQ_STS = 8'h1c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

   // calendar_control_one bit positions
   localparam int unsigned CTL_START = 0;
   localparam int unsigned CTL_RUN = 2;
   localparam int unsigned CTL_BRST = 3;
   localparam int unsigned CTL_OSTOP = 4;
   localparam int unsigned CTL_CRST = 5;
   localparam int unsigned CTL_BUSY = 6;
   localparam int unsigned CTL_MIN_EN = 8;
   localparam int unsigned CTL_HOUR_EN = 9;
   localparam int unsigned CTL_DATE_EN = 10;
   localparam int unsigned CTL_MON_EN = 11;
   localparam int unsigned CTL_YEAR_EN = 12;
   localparam int unsigned CTL_ALM_FLAG = 21;
   localparam int unsigned NUM_ALM_FIELDS = 5;

   // time word layout: second, minute, hour, weekday
   localparam int unsigned TIME_SEC_LSB = 0;
   localparam int unsigned TIME_MIN_LSB = 8;
   localparam int unsigned TIME_HOUR_LSB = 16;
   localparam int unsigned TIME_WDAY_LSB = 24;
   // date word layout: day of month, month, year
   localparam int unsigned DATE_DAY_LSB = 0;
   localparam int unsigned DATE_MON_LSB = 8;
   localparam int unsigned DATE_YEAR_LSB = 16;

   localparam int unsigned SEC_W = 6;
   localparam int unsigned MIN_W = 6;
   localparam int unsigned HOUR_W = 5;
   localparam int unsigned WDAY_W = 3;
   localparam int unsigned DAY_W = 5;
   localparam int unsigned MON_W = 4;
   localparam int unsigned YEAR_W = 7;

   localparam logic [31:0] TIME_WMASK = 32'h071f_3f3f;
   localparam logic [31:0] DATE_WMASK = 32'h007f_0f1f;
   localparam logic [31:0] TIME_RST = 32'h0000_0000;
   localparam logic [31:0] DATE_RST = 32'h0000_0101;
   localparam logic [MON_W-1:0] MON_RST = 4'h1;
   localparam logic [DAY_W-1:0] DAY_RST = 5'h01;

   // interrupt status / mask bits
   localparam int unsigned IRQ_ALARM = 0;
   localparam int unsigned IRQ_SEC = 1;
   localparam int unsigned IRQ_BRST = 2;
   localparam int unsigned IRQ_W = 3;

   typedef enum logic [1:0] {
      RUN_IDLE = 2'b00,
      RUN_LOAD = 2'b01,
      RUN_COUNT = 2'b11
   } rtcarc_run_e;

endpackage

// ### hdl/rtcarc_prescale.sv
`timescale 1ns/100ps
module rtcarc_prescale #(
   parameter int unsigned HALF_CYC = rtcarc_pkg::HALF_SEC_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic hold,
   input wire logic stop,
   output logic sec_tick
);

   localparam int unsigned CW = $clog2(HALF_CYC);

   generate
      if (HALF_CYC < 2) begin : g_bad
         $error("rtcarc_prescale: HALF_CYC must be at least 2");
      end
   endgenerate

   logic [CW-1:0] cnt_r;
   logic half_r;
   logic wrap;

   assign wrap = (cnt_r == '0);

   // counters sit at their reload point while held, so release restarts a full second
   always_ff @(posedge clk) begin
      if (rst || hold || !run) begin
         cnt_r <= CW'(HALF_CYC - 1);
         half_r <= 1'b0;
      end else if (wrap) begin
         cnt_r <= CW'(HALF_CYC - 1);
         half_r <= !half_r;
      end else begin
         cnt_r <= cnt_r - CW'(1);
      end
   end

   // the counter keeps running while stopped; only the tick is withheld
   always_ff @(posedge clk) begin
      if (rst) begin
         sec_tick <= 1'b0;
      end else begin
         sec_tick <= run && !hold && !stop && wrap && half_r;
      end
   end

endmodule

// ### hdl/rtcarc_calendar.sv
`timescale 1ns/100ps
module rtcarc_calendar (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic tick,
   input wire logic [31:0] set_time,
   input wire logic [31:0] set_date,
   output logic [rtcarc_pkg::SEC_W-1:0] sec_r,
   output logic [rtcarc_pkg::MIN_W-1:0] min_r,
   output logic [rtcarc_pkg::HOUR_W-1:0] hour_r,
   output logic [rtcarc_pkg::WDAY_W-1:0] wday_r,
   output logic [rtcarc_pkg::DAY_W-1:0] day_r,
   output logic [rtcarc_pkg::MON_W-1:0] mon_r,
   output logic [rtcarc_pkg::YEAR_W-1:0] year_r
);

   logic [rtcarc_pkg::DAY_W-1:0] dim;
   logic c_min, c_hour, c_day, c_mon, c_year;

   // two-digit year, every fourth year leap
   always_comb begin
      case (mon_r)
         4'h2: dim = (year_r[1:0] == 2'b00) ? 5'd29 : 5'd28;
         4'h4, 4'h6, 4'h9, 4'hb: dim = 5'd30;
         default: dim = 5'd31;
      endcase
   end

   assign c_min = tick && (sec_r == 6'd59);
   assign c_hour = c_min && (min_r == 6'd59);
   assign c_day = c_hour && (hour_r == 5'd23);
   assign c_mon = c_day && (day_r >= dim);
   assign c_year = c_mon && (mon_r == 4'hc);

   always_ff @(posedge clk) begin
      if (rst) begin
         {sec_r, min_r, hour_r, wday_r, year_r} <= '0;
         day_r <= rtcarc_pkg::DAY_RST;
         mon_r <= rtcarc_pkg::MON_RST;
      end else if (load) begin
         sec_r <= set_time[rtcarc_pkg::TIME_SEC_LSB +: rtcarc_pkg::SEC_W];
         min_r <= set_time[rtcarc_pkg::TIME_MIN_LSB +: rtcarc_pkg::MIN_W];
         hour_r <= set_time[rtcarc_pkg::TIME_HOUR_LSB +: rtcarc_pkg::HOUR_W];
         wday_r <= set_time[rtcarc_pkg::TIME_WDAY_LSB +: rtcarc_pkg::WDAY_W];
         day_r <= set_date[rtcarc_pkg::DATE_DAY_LSB +: rtcarc_pkg::DAY_W];
         mon_r <= set_date[rtcarc_pkg::DATE_MON_LSB +: rtcarc_pkg::MON_W];
         year_r <= set_date[rtcarc_pkg::DATE_YEAR_LSB +: rtcarc_pkg::YEAR_W];
      end else if (tick) begin
         sec_r <= c_min ? 6'd0 : sec_r + 6'd1;
         if (c_min) begin
            min_r <= c_hour ? 6'd0 : min_r + 6'd1;
         end
         if (c_hour) begin
            hour_r <= c_day ? 5'd0 : hour_r + 5'd1;
         end
         if (c_day) begin
            wday_r <= (wday_r == 3'd6) ? 3'd0 : wday_r + 3'd1;
            day_r <= c_mon ? rtcarc_pkg::DAY_RST : day_r + 5'd1;
         end
         if (c_mon) begin
            mon_r <= c_year ? rtcarc_pkg::MON_RST : mon_r + 4'h1;
         end
         if (c_year) begin
            year_r <= (year_r == 7'd99) ? 7'd0 : year_r + 7'd1;
         end
      end
   end

endmodule

// ### hdl/rtcarc_top.sv
// What this block does
// [RULE1] Year compare enable adds year setting versus year counter to alarm match.
// [RULE2] Month compare enable adds month setting versus month counter to alarm match.
// [RULE3] Date compare enable adds date setting versus date counter to alarm match.
// [RULE4] Hour compare enable adds hour setting versus hour counter to alarm match.
// [RULE5] Minute compare enable adds minute setting versus minute counter to alarm match.
// [RULE6] Busy reads 1 while output stop, counter reset or a calendar load is active.
// [RULE7] Counter reset bit holds the sub-second and one-second counters in reset.
// [RULE8] Running with counter reset and output stop both 0, settings never reload.
// [RULE9] Software never sets counter reset and output stop together.
// [RULE10] Software sets neither counter reset nor output stop while stopped.
// [RULE11] Output stop withholds the one-second clock; clearing it passes it again.
// [RULE12] Writing 1 to block reset resets the calendar; bit reads 0 when done.
// [RULE13] Read of block reset returns 0 so a write-back cannot retrigger it; here the bit reads 1 while the pulse runs.
// [RULE14] Run status is 1 while counting; clearing start stops and clears it.
// [RULE15] Start copies all settings into the counters, then counting begins.
// [RULE16] Alarm flag sets on enabled-field match; write 0 clears, write 1 ignored.
// [RULE17] A field with compare disabled counts as matching.
// [RULE18] Reserved bits 15 to 13, 7 and 1 read 0 and ignore writes.
`timescale 1ns/100ps
module rtcarc_top #(
   parameter int unsigned HALF_SEC_CYC = rtcarc_pkg::HALF_SEC_CYCLES,
   parameter int unsigned BRST_CYC = rtcarc_pkg::BLK_RST_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   output logic SEC_CLK_OUT
);

   generate
      if (BRST_CYC < 1 || BRST_CYC > 7) begin : g_bad_brst
         $error("rtcarc_top: BRST_CYC must be 1 to 7");
      end
   endgenerate

   rtcarc_pkg::rtcarc_run_e state_r;
   rtcarc_pkg::rtcarc_run_e state_nxt;

   logic [rtcarc_pkg::NUM_ALM_FIELDS-1:0] alm_en_r;
   logic start_r;
   logic crst_r;
   logic ostop_r;
   logic flag_r;
   logic [2:0] brst_cnt_r;
   logic [31:0] alm_time_r;
   logic [31:0] alm_date_r;
   logic [31:0] set_time_r;
   logic [31:0] set_date_r;
   logic [rtcarc_pkg::IRQ_W-1:0] sts_r;
   logic [rtcarc_pkg::IRQ_W-1:0] mask_r;

   logic [rtcarc_pkg::SEC_W-1:0] cnt_sec;
   logic [rtcarc_pkg::MIN_W-1:0] cnt_min;
   logic [rtcarc_pkg::HOUR_W-1:0] cnt_hour;
   logic [rtcarc_pkg::WDAY_W-1:0] cnt_wday;
   logic [rtcarc_pkg::DAY_W-1:0] cnt_day;
   logic [rtcarc_pkg::MON_W-1:0] cnt_mon;
   logic [rtcarc_pkg::YEAR_W-1:0] cnt_year;

   logic setup;
   logic wr_acc;
   logic [31:0] bm;
   logic [31:0] ctrl_rd;
   logic [31:0] ctrl_wv;
   logic [31:0] cnt_time_rd;
   logic [31:0] cnt_date_rd;
   logic [31:0] rd_data;
   logic addr_hit;
   logic wr_ctrl;
   logic wr_set;
   logic blk_rst;
   logic brst_busy;
   logic running;
   logic loading;
   logic busy;
   logic sec_tick;
   logic [rtcarc_pkg::NUM_ALM_FIELDS-1:0] alm_eq;
   logic alm_hit;
   logic [rtcarc_pkg::IRQ_W-1:0] ev;

   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
                                         input logic [31:0] m);
      return (cur & ~m) | (wd & m);
   endfunction

   assign setup = PSEL && !PENABLE;
   assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
   assign bm = lane_mask(PSTRB);
   assign wr_ctrl = wr_acc && (PADDR == rtcarc_pkg::OFS_CTRL1);
   assign wr_set = wr_acc && ((PADDR == rtcarc_pkg::OFS_SET_TIME) ||
                              (PADDR == rtcarc_pkg::OFS_SET_DATE));
   assign ctrl_wv = merge(ctrl_rd, PWDATA, bm);

   assign brst_busy = (brst_cnt_r != 3'd0);
   assign blk_rst = RST || brst_busy; // [RULE12]
   assign running = (state_r == rtcarc_pkg::RUN_COUNT);
   assign loading = (state_r == rtcarc_pkg::RUN_LOAD);
   assign busy = ostop_r || crst_r || loading; // [RULE6]

   // control word as software sees it; unlisted positions stay 0 [RULE18]
   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[rtcarc_pkg::CTL_MIN_EN +: rtcarc_pkg::NUM_ALM_FIELDS] = alm_en_r;
      ctrl_rd[rtcarc_pkg::CTL_ALM_FLAG] = flag_r;
      ctrl_rd[rtcarc_pkg::CTL_BUSY] = busy;
      ctrl_rd[rtcarc_pkg::CTL_CRST] = crst_r;
      ctrl_rd[rtcarc_pkg::CTL_OSTOP] = ostop_r;
      // only 1 while the pulse runs, so a read right after the write can still see it [RULE13]
      ctrl_rd[rtcarc_pkg::CTL_BRST] = brst_busy;
      ctrl_rd[rtcarc_pkg::CTL_RUN] = running; // [RULE14]
      ctrl_rd[rtcarc_pkg::CTL_START] = start_r;
   end

   always_comb begin
      cnt_time_rd = '0;
      cnt_time_rd[rtcarc_pkg::TIME_SEC_LSB +: rtcarc_pkg::SEC_W] = cnt_sec;
      cnt_time_rd[rtcarc_pkg::TIME_MIN_LSB +: rtcarc_pkg::MIN_W] = cnt_min;
      cnt_time_rd[rtcarc_pkg::TIME_HOUR_LSB +: rtcarc_pkg::HOUR_W] = cnt_hour;
      cnt_time_rd[rtcarc_pkg::TIME_WDAY_LSB +: rtcarc_pkg::WDAY_W] = cnt_wday;
      cnt_date_rd = '0;
      cnt_date_rd[rtcarc_pkg::DATE_DAY_LSB +: rtcarc_pkg::DAY_W] = cnt_day;
      cnt_date_rd[rtcarc_pkg::DATE_MON_LSB +: rtcarc_pkg::MON_W] = cnt_mon;
      cnt_date_rd[rtcarc_pkg::DATE_YEAR_LSB +: rtcarc_pkg::YEAR_W] = cnt_year;
   end

   always_comb begin
      rd_data = '0;
      addr_hit = 1'b1;
      case (PADDR)
         rtcarc_pkg::OFS_CTRL1: rd_data = ctrl_rd;
         rtcarc_pkg::OFS_ALM_TIME: rd_data = alm_time_r;
         rtcarc_pkg::OFS_ALM_DATE: rd_data = alm_date_r;
         rtcarc_pkg::OFS_SET_TIME: rd_data = set_time_r;
         rtcarc_pkg::OFS_SET_DATE: rd_data = set_date_r;
         rtcarc_pkg::OFS_CNT_TIME: rd_data = cnt_time_rd;
         rtcarc_pkg::OFS_CNT_DATE: rd_data = cnt_date_rd;
         rtcarc_pkg::OFS_IRQ_STS: rd_data = {{(32-rtcarc_pkg::IRQ_W){1'b0}}, sts_r};
         rtcarc_pkg::OFS_IRQ_MASK: rd_data = {{(32-rtcarc_pkg::IRQ_W){1'b0}}, mask_r};
         default: addr_hit = 1'b0;
      endcase
   end

   // one wait-free answer: ready and data follow the setup cycle
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         PREADY <= 1'b0;
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= setup;
         PRDATA <= setup ? rd_data : 32'h0000_0000;
         PSLVERR <= setup && !addr_hit;
      end
   end

   // run control: start loads the settings, then counting begins [RULE15]
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rtcarc_pkg::RUN_IDLE: begin
            if (start_r) begin
               state_nxt = rtcarc_pkg::RUN_LOAD;
            end
         end
         rtcarc_pkg::RUN_LOAD: begin
            state_nxt = start_r ? rtcarc_pkg::RUN_COUNT : rtcarc_pkg::RUN_IDLE;
         end
         rtcarc_pkg::RUN_COUNT: begin
            if (!start_r) begin
               state_nxt = rtcarc_pkg::RUN_IDLE; // [RULE14]
            end else if (wr_set && (crst_r || ostop_r)) begin
               // a live rewrite is only taken while the tick is held off [RULE8]
               state_nxt = rtcarc_pkg::RUN_LOAD;
            end
         end
         default: state_nxt = rtcarc_pkg::RUN_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (blk_rst) begin
         state_r <= rtcarc_pkg::RUN_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // control bits; the block reset clears them along with the counters
   always_ff @(posedge SYS_CLK) begin
      if (blk_rst) begin
         alm_en_r <= '0;
         start_r <= 1'b0;
         crst_r <= 1'b0;
         ostop_r <= 1'b0;
      end else if (wr_ctrl) begin
         alm_en_r <= ctrl_wv[rtcarc_pkg::CTL_MIN_EN +: rtcarc_pkg::NUM_ALM_FIELDS];
         start_r <= ctrl_wv[rtcarc_pkg::CTL_START];
         // taken as written: both bits set, or set while stopped, is not guarded [RULE9] [RULE10]
         crst_r <= ctrl_wv[rtcarc_pkg::CTL_CRST]; // [RULE7]
         ostop_r <= ctrl_wv[rtcarc_pkg::CTL_OSTOP]; // [RULE11]
      end
   end

   // self-clearing block reset, kept out of its own reset path
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         brst_cnt_r <= 3'd0;
      end else if (brst_busy) begin
         brst_cnt_r <= brst_cnt_r - 3'd1;
      end else if (wr_ctrl && ctrl_wv[rtcarc_pkg::CTL_BRST]) begin
         brst_cnt_r <= 3'(BRST_CYC); // [RULE12]
      end
   end

   // alarm and calendar settings; only the defined field bits store
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         alm_time_r <= rtcarc_pkg::TIME_RST;
         alm_date_r <= rtcarc_pkg::DATE_RST;
         set_time_r <= rtcarc_pkg::TIME_RST;
         set_date_r <= rtcarc_pkg::DATE_RST;
      end else if (wr_acc) begin
         if (PADDR == rtcarc_pkg::OFS_ALM_TIME) begin
            alm_time_r <= merge(alm_time_r, PWDATA, bm) & rtcarc_pkg::TIME_WMASK;
         end
         if (PADDR == rtcarc_pkg::OFS_ALM_DATE) begin
            alm_date_r <= merge(alm_date_r, PWDATA, bm) & rtcarc_pkg::DATE_WMASK;
         end
         if (PADDR == rtcarc_pkg::OFS_SET_TIME) begin
            set_time_r <= merge(set_time_r, PWDATA, bm) & rtcarc_pkg::TIME_WMASK;
         end
         if (PADDR == rtcarc_pkg::OFS_SET_DATE) begin
            set_date_r <= merge(set_date_r, PWDATA, bm) & rtcarc_pkg::DATE_WMASK;
         end
      end
   end

   rtcarc_prescale #(
      .HALF_CYC(HALF_SEC_CYC)
   ) u_prescale (
      .clk(SYS_CLK),
      .rst(blk_rst),
      .run(running),
      .hold(crst_r), // [RULE7]
      .stop(ostop_r), // [RULE11]
      .sec_tick(sec_tick)
   );

   rtcarc_calendar u_calendar (
      .clk(SYS_CLK),
      .rst(blk_rst),
      .load(loading), // [RULE15]
      .tick(sec_tick),
      .set_time(set_time_r),
      .set_date(set_date_r),
      .sec_r(cnt_sec),
      .min_r(cnt_min),
      .hour_r(cnt_hour),
      .wday_r(cnt_wday),
      .day_r(cnt_day),
      .mon_r(cnt_mon),
      .year_r(cnt_year)
   );

   // per-field compare, each bit ordered like the enable field
   always_comb begin
      alm_eq = '0;
      alm_eq[0] = (alm_time_r[rtcarc_pkg::TIME_MIN_LSB +: rtcarc_pkg::MIN_W] ==
                   cnt_min); // [RULE5]
      alm_eq[1] = (alm_time_r[rtcarc_pkg::TIME_HOUR_LSB +: rtcarc_pkg::HOUR_W] ==
                   cnt_hour); // [RULE4]
      alm_eq[2] = (alm_date_r[rtcarc_pkg::DATE_DAY_LSB +: rtcarc_pkg::DAY_W] ==
                   cnt_day); // [RULE3]
      alm_eq[3] = (alm_date_r[rtcarc_pkg::DATE_MON_LSB +: rtcarc_pkg::MON_W] ==
                   cnt_mon); // [RULE2]
      alm_eq[4] = (alm_date_r[rtcarc_pkg::DATE_YEAR_LSB +: rtcarc_pkg::YEAR_W] ==
                   cnt_year); // [RULE1]
   end

   // disabled fields pass; with none enabled there is no alarm at all [RULE17]
   assign alm_hit = running && (|alm_en_r) && (&(alm_eq | ~alm_en_r));

   // set beats a same-cycle clear; writing 1 leaves the flag alone [RULE16]
   always_ff @(posedge SYS_CLK) begin
      if (blk_rst) begin
         flag_r <= 1'b0;
      end else if (alm_hit) begin
         flag_r <= 1'b1;
      end else if (wr_ctrl && !ctrl_wv[rtcarc_pkg::CTL_ALM_FLAG]) begin
         flag_r <= 1'b0;
      end
   end

   always_comb begin
      ev = '0;
      ev[rtcarc_pkg::IRQ_ALARM] = alm_hit && !flag_r;
      ev[rtcarc_pkg::IRQ_SEC] = sec_tick;
      ev[rtcarc_pkg::IRQ_BRST] = (brst_cnt_r == 3'd1);
   end

   // sticky status, write 1 to clear, new events win over the clear
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         sts_r <= '0;
         mask_r <= '0;
      end else begin
         if (wr_acc && PADDR == rtcarc_pkg::OFS_IRQ_STS) begin
            sts_r <= (sts_r & ~(PWDATA[rtcarc_pkg::IRQ_W-1:0] & bm[rtcarc_pkg::IRQ_W-1:0])) | ev;
         end else begin
            sts_r <= sts_r | ev;
         end
         if (wr_acc && PADDR == rtcarc_pkg::OFS_IRQ_MASK) begin
            mask_r <= (mask_r & ~bm[rtcarc_pkg::IRQ_W-1:0]) |
                      (PWDATA[rtcarc_pkg::IRQ_W-1:0] & bm[rtcarc_pkg::IRQ_W-1:0]);
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         IRQ <= 1'b0;
         SEC_CLK_OUT <= 1'b0;
      end else begin
         IRQ <= |(sts_r & mask_r);
         SEC_CLK_OUT <= sec_tick; // [RULE11]
      end
   end

endmodule

// ### bench/rtcarc_asserts.sv
`timescale 1ns/100ps
module rtcarc_asserts #(
   parameter int unsigned BRST_CYC = 4
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic IRQ,
   input wire logic SEC_CLK_OUT
);
   logic ctl_rd;
   logic ctl_wr;
   logic [1:0] gate_r;
   logic [3:0] age_r;
   assign ctl_rd = PSEL && PENABLE && PREADY && !PWRITE && PADDR == 8'h00;
   assign ctl_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00 && PSTRB[0];
   // mirror of counter reset and output stop; a block reset clears both
   always_ff @(posedge SYS_CLK) begin
      if (RST || (ctl_wr && PWDATA[3])) begin
         gate_r <= 2'h0;
      end else if (ctl_wr) begin
         gate_r <= PWDATA[5:4];
      end
   end
   // cycles since the last block reset request, saturating
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         age_r <= 4'hf;
      end else if (ctl_wr && PWDATA[3]) begin
         age_r <= 4'h0;
      end else if (age_r != 4'hf) begin
         age_r <= age_r + 4'h1;
      end
   end
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_pulse;
      PREADY ##1 !PREADY;
   endsequence
   a_ready_after_setup:
      assert property (s_setup |=> s_pulse)
      else $error("no single ready pulse after setup");
   a_idle_data_zero:
      assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR)
      else $error("data or error outside an answer");
   a_unaligned_error:
      assert property (s_setup ##0 PADDR[1:0] != 2'h0 |=> PSLVERR && PRDATA == 32'h0)
      else $error("unaligned access not refused");
   a_resv_read_zero:
      assert property (ctl_rd |-> PRDATA[15:13] == 3'h0 && !PRDATA[7] && !PRDATA[1])
      else $error("reserved control bit reads one");
   a_busy_flags:
      assert property (ctl_rd && (PRDATA[4] || PRDATA[5]) |-> PRDATA[6])
      else $error("busy low while stop or hold set");
   a_stop_no_tick:
      assert property (gate_r[0] && $past(gate_r[0], 3) |-> !SEC_CLK_OUT)
      else $error("second pulse while output stopped");
   a_hold_no_tick:
      assert property (gate_r[1] && $past(gate_r[1], 3) |-> !SEC_CLK_OUT)
      else $error("second pulse while counters held");
   a_brst_reads_zero:
      assert property (ctl_rd && age_r > BRST_CYC + 3 |-> !PRDATA[3])
      else $error("block reset bit still reads one");
endmodule

bind rtcarc_top rtcarc_asserts #(.BRST_CYC(BRST_CYC)) u_chk (
   .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .IRQ(IRQ), .SEC_CLK_OUT(SEC_CLK_OUT)
);

// ### bench/tb.sv
`timescale 1ns/100ps
module tb;
   localparam logic [31:0] TM = 32'hffff_ff00;
   localparam logic [31:0] FLG = 32'h0020_0000;
   typedef struct {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic e;
   } rtcarc_row_s;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, sec_out, e;
   logic [7:0] paddr;
   logic [3:0] pstrb;
   logic [31:0] pwdata, prdata, q;
   int error_cnt = 0;
   int check_count = 0;
   int n;
   rtcarc_row_s rows [10] = '{
      '{8'h00, 32'h0000_ff82, 32'h0000_1f00, 1'b0},
      '{8'h04, 32'hffff_ffff, 32'h071f_3f3f, 1'b0},
      '{8'h08, 32'hffff_ffff, 32'h007f_0f1f, 1'b0},
      '{8'h0c, 32'hffff_ffff, 32'h071f_3f3f, 1'b0},
      '{8'h10, 32'hffff_ffff, 32'h007f_0f1f, 1'b0},
      '{8'h20, 32'hffff_ffff, 32'h0000_0007, 1'b0},
      '{8'h14, 32'hffff_ffff, 32'h0000_0000, 1'b0},
      '{8'h18, 32'hffff_ffff, 32'h0000_0101, 1'b0},
      '{8'h40, 32'hffff_ffff, 32'h0000_0000, 1'b1},
      '{8'h06, 32'hffff_ffff, 32'h0000_0000, 1'b1}
   };
   rtcarc_top #(.HALF_SEC_CYC(4), .BRST_CYC(4)) uut (
      .SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IRQ(irq), .SEC_CLK_OUT(sec_out)
   );
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] x);
      check_count++;
      if (seen !== x) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", s, x, seen);
      end
   endtask
   // one transfer, then an idle edge so the next call never re-drives psel in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) error_cnt++;
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string s, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(s, q & m, x);
   endtask
   task automatic ticks(input int c, input int x);
      n = 0;
      repeat (c) begin
         @(posedge clk);
         if (sec_out !== 1'b0) n++;
      end
      chk("sec pulses", n, x);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (6000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'b1000, 40'h0, 4'hf};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("irq", irq, 32'h0);
      rd("ctrl", 8'h00, '1, 32'h0);
      rd("set date", 8'h10, '1, 32'h0000_0101);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd("table", rows[i].a, '1, rows[i].x);
         chk("err", e, rows[i].e);
      end
      $display("test registers done");
      wr(8'h0c, 32'h0203_0500);
      wr(8'h10, 32'h0018_021c);
      wr(8'h00, 32'h1);
      repeat (3) @(posedge clk);
      rd("run", 8'h00, 32'h45, 32'h5);
      rd("load time", 8'h14, TM, 32'h0203_0500);
      rd("load date", 8'h18, '1, 32'h0018_021c);
      wr(8'h0c, 32'h0203_0900);
      repeat (4) @(posedge clk);
      rd("no reload", 8'h14, TM, 32'h0203_0500);
      $display("test start done");
      wr(8'h00, 32'h11);
      rd("busy stop", 8'h00, 32'h40, 32'h40);
      ticks(40, 0);
      wr(8'h0c, 32'h0203_0900);
      repeat (4) @(posedge clk);
      rd("reload", 8'h14, TM, 32'h0203_0900);
      wr(8'h00, 32'h1);
      repeat (10) @(posedge clk);
      ticks(40, 5);
      wr(8'h00, 32'h21);
      rd("busy hold", 8'h00, 32'h40, 32'h40);
      ticks(40, 0);
      wr(8'h00, 32'h1);
      rd("busy idle", 8'h00, 32'h40, 32'h0);
      $display("test second done");
      // alarm time matches the counters, alarm date matches nothing
      wr(8'h04, 32'h0003_0900);
      wr(8'h08, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr(8'h00, 32'h1);
         wr(8'h00, 32'h1 | (32'h100 << i));
         repeat (3) @(posedge clk);
         rd("alarm", 8'h00, FLG, FLG * (i < 2));
      end
      wr(8'h00, 32'h101);
      wr(8'h00, FLG | 32'h1);
      rd("flag w1", 8'h00, FLG, FLG);
      wr(8'h00, 32'h1);
      rd("flag w0", 8'h00, FLG, 32'h0);
      $display("test alarm done");
      wr(8'h20, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq on", irq, 32'h1);
      wr(8'h20, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", irq, 32'h0);
      wr(8'h1c, 32'h1);
      rd("sts clear", 8'h1c, 32'h1, 32'h0);
      wr(8'h20, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq cleared", irq, 32'h0);
      $display("test irq done");
      wr(8'h00, 32'h0);
      rd("stopped", 8'h00, 32'h5, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      repeat (30) @(posedge clk);
      rd("frozen", 8'h14, '1, q);
      wr(8'h00, 32'h1f01);
      wr(8'h00, 32'h1f09);
      repeat (10) @(posedge clk);
      rd("blk ctrl", 8'h00, '1, 32'h0);
      rd("blk date", 8'h18, '1, 32'h0000_0101);
      rd("blk sts", 8'h1c, '1, 32'h6);
      // only the low byte lane is strobed; the other lanes keep their value
      pstrb <= 4'h1;
      wr(8'h10, 32'h0000_00ff);
      pstrb <= 4'hf;
      rd("strobe", 8'h10, '1, 32'h0018_021f);
      $display("test block reset done");
      finish_test();
   end
endmodule
